// ==== hw/adcsq_params.svh ====
// Purpose: Register map, field positions, reset values and timing counts of the sequencer.
// Assumes: APB byte addresses on PADDR[7:0], one aligned 32-bit word per register.
// Notes:   Times are held in their own unit and converted to MCLK cycles here.
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH

// Register byte offsets.
`define ADCSQ_OFF_CTRL0   8'h00
`define ADCSQ_OFF_CTRL1   8'h04
`define ADCSQ_OFF_RESH    8'h08
`define ADCSQ_OFF_RESL    8'h0c
`define ADCSQ_OFF_STATUS  8'h10
`define ADCSQ_OFF_AMASK   8'h14
`define ADCSQ_OFF_PORT    8'h18

// Control word 0 fields.
`define ADCSQ_CS_HI       7
`define ADCSQ_CS_LO       6
`define ADCSQ_CH_HI       5
`define ADCSQ_CH_LO       3
`define ADCSQ_GO_BIT      2
`define ADCSQ_PWR_BIT     0
// Control word 1 and status fields.
`define ADCSQ_FMT_BIT     7
`define ADCSQ_DONE_BIT    0
`define ADCSQ_INTEN_BIT   1

// Reset values.
`define ADCSQ_RST_AMASK   8'hff

// Clock select codes and divider ratios in oscillator periods.
`define ADCSQ_CS_RC       2'h3
`define ADCSQ_DIV_00      6'h02
`define ADCSQ_DIV_01      6'h08
`define ADCSQ_DIV_10      6'h20

// Timing: oscillator period, instruction cycle and sequence lengths.
`define ADCSQ_TOSC_NS     10
`define ADCSQ_TCY_NS      40
`define ADCSQ_TCY_CYC     3'((`ADCSQ_TCY_NS + `ADCSQ_TOSC_NS - 1) / `ADCSQ_TOSC_NS)
`define ADCSQ_CONV_TAD    4'hc
`define ADCSQ_HOLD_TAD    4'h2

`endif

// ==== hw/adcsq_pkg.sv ====
// Purpose: Types shared by the conversion sequencer modules.
// Assumes: Nothing beyond the parameter header.
// Notes:   States carry no explicit codes.
package adcsq_pkg;

   typedef enum logic [2:0] {ST_OFF, ST_ACQ, ST_DELAY, ST_CONV, ST_HOLD, ST_PDOWN} adcsq_state_e;

   typedef struct packed {
      adcsq_state_e state;
      logic         go;
      logic         pwr;
      logic [1:0]   csel;
      logic [2:0]   chan;
      logic         fmt;
      logic         done;
      logic         inten;
      logic [7:0]   amask;
      logic [7:0]   res_hi;
      logic [7:0]   res_lo;
      logic [9:0]   sar;
      logic [3:0]   conv_bit_period;
      logic [2:0]   dly;
      logic         sample;
      logic         powered;
      logic         wake;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
   } adcsq_seq_s;

   typedef struct packed {
      logic [4:0] cnt;
      logic       tick;
      logic       s1;
      logic       s2;
      logic       s3;
   } adcsq_tick_s;

endpackage

// ==== hw/adcsq_tick_if.sv ====
// Purpose: Carries clock select, restart and bit-period tick between sequencer and divider.
// Assumes: One clock domain, MCLK.
// Notes:   rc_level is the raw internal RC oscillator level, not yet synchronised.
`timescale 1ns/1ps
interface adcsq_tick_if;
   logic [1:0] sel;
   logic       restart;
   logic       rc_level;
   logic       tick;
   modport seq (output sel, output restart, output rc_level, input tick);
   modport gen (input sel, input restart, input rc_level, output tick);
endinterface

// ==== hw/adcsq_tick_gen.sv ====
// Purpose: Produces one pulse per conversion bit period from MCLK or the RC oscillator.
// Assumes: Oscillator period equals one MCLK period.
// Notes:   With a divided select, a restart realigns the period so the first segment is one full bit period; RC edges are not realigned.
`timescale 1ns/1ps
`include "adcsq_params.svh"
module adcsq_tick_gen (
   input  wire logic clk,          // MCLK
   input  wire logic rst,          // Synchronous reset, active high
   adcsq_tick_if.gen tif           // Select, restart and tick
);
   import adcsq_pkg::*;

   adcsq_tick_s r;
   adcsq_tick_s n;
   logic        rc_edge;

   // Divider ratio for each oscillator-derived select code.
   // The ratio of 32 needs a sixth bit; the counter itself only reaches 31.
   function automatic logic [5:0] div_limit(input logic [1:0] sel);
      case (sel)
         2'h0:    div_limit = `ADCSQ_DIV_00;
         2'h1:    div_limit = `ADCSQ_DIV_01;
         default: div_limit = `ADCSQ_DIV_10;
      endcase
   endfunction

   assign rc_edge = r.s2 & ~r.s3;  // Only second and third stages are examined. [R20]
   assign tif.tick = r.tick;

   // The RC level runs free of MCLK, so it passes two flops before any use. [R20]
   always_comb
   begin
      n = r;
      n.s1 = tif.rc_level;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.tick = 1'b0;
      if (tif.restart)
      begin
         n.cnt = 5'h00;
      end
      else if (tif.sel == `ADCSQ_CS_RC)
      begin
         n.tick = rc_edge;  // [R1]
      end
      else if ({1'b0, r.cnt} == div_limit(tif.sel) - 6'h01)
      begin
         n.cnt = 5'h00;
         n.tick = 1'b1;  // [R1]
      end
      else
      begin
         n.cnt = r.cnt + 5'h01;
      end
      if (rst)
      begin
         n = '0;
      end
   end

   // State register.
   always_ff @(posedge clk)
   begin
      r <= n;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_restart_fast;
      tif.restart && tif.sel == 2'h0 ##1 !tif.restart [*2];
   endsequence
   a_fast_period: assert property (s_restart_fast |=> tif.tick)  // [R1]
      else $error("Two-period select did not tick after two cycles.");
endmodule

// ==== hw/adcsq_seq.sv ====
// Purpose: Conversion sequencer for a 10-bit successive-approximation converter, APB slave.
// Assumes: Analog core answers AN_COMP for the trial code within one bit period.
// Notes:   Instruction cycle is four MCLK periods; result words are never reset.
// Summary of operation
// [R1] Clock select picks 2, 8 or 32 oscillator periods per bit, or RC.
// [R2] Software keeps the bit period at or above 1.6 microseconds.
// [R3] A conversion takes twelve bit periods from start to completion.
// [R4] After completion, two bit periods pass with the hold capacitor disconnected.
// [R5] Clearing go mid-conversion aborts it and leaves the result untouched.
// [R6] After an abort, wait two bit periods, then acquire the selected channel.
// [R7] First segment after go lasts between one instruction cycle and one bit period.
// [R8] Software enables the converter before it sets go.
// [R9] Port reads show zero on every pin configured as analog input.
// [R10] Conversion ignores channel value and pin direction; driven pins convert own level.
// [R11] The result is justified by format select, six unused bits zero.
// [R12] While disabled the two result words are plain 8-bit read/write registers.
// [R13] With RC clock, conversion starts one instruction cycle after go.
// [R14] RC conversion completes in sleep, wakes if enabled, else powers down.
// [R15] Sleep with a non-RC clock aborts the conversion and powers down.
// [R16] Reset restores controls, turns the converter off and aborts conversion.
// [R17] Reset does not initialise the result words.
// [R18] Completion loads the result, clears go and sets the done flag.
// [R19] Format one: right justified; format zero: left justified.
// [R20] RC domain signals are synchronised before the sequencer uses them.
`timescale 1ns/1ps
`include "adcsq_params.svh"
module adcsq_seq (
   input  wire logic        MCLK,        // System clock, 100 MHz
   input  wire logic        RST,         // Synchronous reset, active high
   input  wire logic        PSEL,        // APB select
   input  wire logic        PENABLE,     // APB access phase
   input  wire logic        PWRITE,      // APB direction, high for write
   input  wire logic [7:0]  PADDR,       // APB byte address
   input  wire logic [31:0] PWDATA,      // APB write data
   output logic      [31:0] PRDATA,      // APB read data
   output logic             PREADY,      // APB ready
   output logic             PSLVERR,     // APB error on unmapped address
   input  wire logic        SLEEP,       // Device sleep level
   input  wire logic        RC_CLK,      // Internal RC oscillator level
   input  wire logic [7:0]  PIN_IN,      // Port pin levels
   input  wire logic        AN_COMP,     // Comparator: input at or above trial code
   output logic      [2:0]  AN_CHANNEL,  // Selected input channel
   output logic             AN_SAMPLE,   // Hold capacitor connected to channel
   output logic      [9:0]  AN_TRIAL,    // Trial code for the comparator
   output logic             AN_POWER,    // Analog core powered
   output logic             WAKE,        // One-cycle wake request from sleep
   output logic             DONE_FLAG    // Conversion done flag
);
   import adcsq_pkg::*;

   adcsq_seq_s r;
   adcsq_seq_s n;
   adcsq_tick_if tif ();
   logic        rd_req;
   logic        wr_req;
   logic        wr_ctrl0;
   logic        done_set;
   logic        abort_evt;
   logic        is_rc;
   logic        go_start;

   // Places the 10-bit code in the 16-bit pair, unused bits zero.
   function automatic logic [15:0] justify(input logic fmt, input logic [9:0] code);
      justify = fmt ? {6'h00, code} : {code, 6'h00};  // [R11] [R19]
   endfunction

   // Flags an address that maps to no register.
   function automatic logic unmapped(input logic [7:0] addr);
      case (addr)
         `ADCSQ_OFF_CTRL0, `ADCSQ_OFF_CTRL1, `ADCSQ_OFF_RESH, `ADCSQ_OFF_RESL,
         `ADCSQ_OFF_STATUS, `ADCSQ_OFF_AMASK, `ADCSQ_OFF_PORT: unmapped = 1'b0;
         default: unmapped = 1'b1;
      endcase
   endfunction

   adcsq_tick_gen u_tick (
      .clk (MCLK),
      .rst (RST),
      .tif (tif.gen)
   );

   // The read answer is prepared in the first access cycle, the write lands with PREADY.
   assign rd_req   = PSEL & PENABLE & ~r.pready;
   assign wr_req   = PSEL & PENABLE & r.pready & PWRITE & ~r.pslverr;
   assign wr_ctrl0 = wr_req & (PADDR == `ADCSQ_OFF_CTRL0);
   assign is_rc    = r.csel == `ADCSQ_CS_RC;
   assign go_start = wr_ctrl0 & PWDATA[`ADCSQ_GO_BIT] & ~r.go & r.pwr & (r.state == ST_ACQ);
   assign tif.sel      = r.csel;
   assign tif.rc_level = RC_CLK;

   // Next-state logic: bus writes first, then the conversion sequence.
   always_comb
   begin
      n = r;
      n.pready = rd_req;
      n.wake = 1'b0;
      done_set = 1'b0;
      abort_evt = 1'b0;
      tif.restart = 1'b0;
      if (rd_req)
      begin
         n.pslverr = unmapped(PADDR);
         case (PADDR)
            `ADCSQ_OFF_CTRL0:  n.prdata = {24'h000000, r.csel, r.chan, r.go, 1'b0, r.pwr};
            `ADCSQ_OFF_CTRL1:  n.prdata = {24'h000000, r.fmt, 7'h00};
            `ADCSQ_OFF_RESH:   n.prdata = {24'h000000, r.res_hi};
            `ADCSQ_OFF_RESL:   n.prdata = {24'h000000, r.res_lo};
            `ADCSQ_OFF_STATUS: n.prdata = {30'h00000000, r.inten, r.done};
            `ADCSQ_OFF_AMASK:  n.prdata = {24'h000000, r.amask};
            `ADCSQ_OFF_PORT:   n.prdata = {24'h000000, PIN_IN & ~r.amask};  // [R9]
            default:           n.prdata = 32'h00000000;
         endcase
      end
      // Register writes.
      if (wr_ctrl0)
      begin
         n.csel = PWDATA[`ADCSQ_CS_HI:`ADCSQ_CS_LO];
         n.chan = PWDATA[`ADCSQ_CH_HI:`ADCSQ_CH_LO];
         n.go   = PWDATA[`ADCSQ_GO_BIT] & (r.go | go_start);  // Taken only in acquire. [R8]
         n.pwr  = PWDATA[`ADCSQ_PWR_BIT];
      end
      if (wr_req && PADDR == `ADCSQ_OFF_CTRL1)
      begin
         n.fmt = PWDATA[`ADCSQ_FMT_BIT];
      end
      if (wr_req && PADDR == `ADCSQ_OFF_AMASK)
      begin
         n.amask = PWDATA[7:0];
      end
      if (wr_req && PADDR == `ADCSQ_OFF_STATUS)
      begin
         n.inten = PWDATA[`ADCSQ_INTEN_BIT];
         if (PWDATA[`ADCSQ_DONE_BIT])
         begin
            n.done = 1'b0;
         end
      end
      // Software owns the result words only while nothing can overwrite them.
      if (wr_req && PADDR == `ADCSQ_OFF_RESH && !r.pwr)
      begin
         n.res_hi = PWDATA[7:0];  // [R12]
      end
      if (wr_req && PADDR == `ADCSQ_OFF_RESL && !r.pwr)
      begin
         n.res_lo = PWDATA[7:0];  // [R12]
      end
      // Conversion sequence.
      case (r.state)
         ST_OFF:
         begin
            if (n.pwr)
            begin
               n.state = ST_ACQ;
            end
         end
         ST_ACQ:
         begin
            if (go_start && is_rc)
            begin
               n.state = ST_DELAY;  // [R13]
               n.dly = 3'h0;
            end
            else if (go_start)
            begin
               n.state = ST_CONV;
               n.conv_bit_period = 4'h0;
               n.sar = 10'h000;
               tif.restart = 1'b1;  // [R7]
            end
            else if (SLEEP && !is_rc)
            begin
               n.state = ST_PDOWN;
            end
         end
         ST_DELAY:
         begin
            if (!n.go)
            begin
               n.state = ST_ACQ;
            end
            else if (r.dly == `ADCSQ_TCY_CYC - 3'h1)
            begin
               n.state = ST_CONV;  // [R13]
               n.conv_bit_period = 4'h0;
               n.sar = 10'h000;
               tif.restart = 1'b1;
            end
            else
            begin
               n.dly = r.dly + 3'h1;
            end
         end
         ST_CONV:
         begin
            if (!n.go)
            begin
               abort_evt = 1'b1;  // Result words are left as they were. [R5]
               n.state = ST_HOLD;
               n.conv_bit_period = 4'h0;
               tif.restart = 1'b1;
            end
            else if (SLEEP && !is_rc)
            begin
               abort_evt = 1'b1;  // [R15]
               n.go = 1'b0;
               n.state = ST_PDOWN;
            end
            else if (tif.tick)
            begin
               n.conv_bit_period = r.conv_bit_period + 4'h1;
               if (r.conv_bit_period == 4'h0)
               begin
                  n.sar[9] = 1'b1;
               end
               else if (r.conv_bit_period <= 4'ha)
               begin
                  // Bit under test is decided; the next lower bit becomes the trial.
                  n.sar[4'ha - r.conv_bit_period] = AN_COMP;
                  if (r.conv_bit_period != 4'ha)
                  begin
                     n.sar[4'h9 - r.conv_bit_period] = 1'b1;
                  end
               end
               if (r.conv_bit_period == `ADCSQ_CONV_TAD - 4'h1)
               begin
                  {n.res_hi, n.res_lo} = justify(r.fmt, r.sar);  // [R3] [R11] [R18]
                  n.go = 1'b0;  // [R18]
                  done_set = 1'b1;  // [R18]
                  n.wake = SLEEP & r.inten;  // [R14]
                  n.state = ST_HOLD;
                  n.conv_bit_period = 4'h0;
               end
            end
         end
         ST_HOLD:
         begin
            if (tif.tick)
            begin
               n.conv_bit_period = r.conv_bit_period + 4'h1;
               if (r.conv_bit_period == `ADCSQ_HOLD_TAD - 4'h1)
               begin
                  n.state = (SLEEP && !r.inten) ? ST_PDOWN : ST_ACQ;  // [R4] [R6] [R14]
               end
            end
         end
         ST_PDOWN:
         begin
            if (!SLEEP)
            begin
               n.state = ST_ACQ;
            end
         end
         default:
         begin
            n.state = ST_OFF;
         end
      endcase
      // Turning the converter off ends any activity at once.
      if (!n.pwr)
      begin
         n.state = ST_OFF;
         n.go = 1'b0;
      end
      // A completion in the same cycle as a software clear keeps the flag.
      n.done = n.done | done_set;
      n.sample = n.state == ST_ACQ;  // [R4] [R6]
      n.powered = n.state != ST_OFF && n.state != ST_PDOWN;  // [R14] [R15]
      if (RST)
      begin
         n = '0;  // [R16]
         n.state = ST_OFF;
         n.amask = `ADCSQ_RST_AMASK;
         n.res_hi = r.res_hi;  // [R17]
         n.res_lo = r.res_lo;  // [R17]
      end
   end

   // State register.
   always_ff @(posedge MCLK)
   begin
      r <= n;
   end

   // Every output comes straight from the state register.
   assign PRDATA     = r.prdata;
   assign PREADY     = r.pready;
   assign PSLVERR    = r.pslverr;
   assign AN_CHANNEL = r.chan;  // Channel passes on whatever the pin direction. [R10]
   assign AN_SAMPLE  = r.sample;
   assign AN_TRIAL   = r.sar;
   assign AN_POWER   = r.powered;
   assign WAKE       = r.wake;
   assign DONE_FLAG  = r.done;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   sequence s_complete;
      r.state == ST_CONV && !wr_ctrl0 && !(SLEEP && !is_rc) && tif.tick &&
         r.conv_bit_period == `ADCSQ_CONV_TAD - 4'h1;
   endsequence
   sequence s_hold_end;
      r.state == ST_HOLD && tif.tick && r.conv_bit_period == 4'h1 && !wr_ctrl0;
   endsequence

   a_ready_pulse: assert property (r.pready |=> !r.pready)
      else $error("PREADY stood for more than one cycle.");
   a_done_loads: assert property (s_complete |=> !r.go && r.done && r.state == ST_HOLD)  // [R18]
      else $error("Completion did not clear go and set done.");
   a_abort_keep: assert property (abort_evt |=> $stable(r.res_hi) && $stable(r.res_lo))  // [R5]
      else $error("Abort changed the result words.");
   a_hold_release: assert property ((s_hold_end and !SLEEP) |=> r.sample)  // [R4] [R6]
      else $error("Acquisition did not restart after two bit periods.");
   a_hold_open: assert property (r.state == ST_HOLD |-> !r.sample)  // [R4]
      else $error("Hold capacitor connected during the hold-off.");
   a_port_mask: assert property (rd_req && PADDR == `ADCSQ_OFF_PORT |=>
      (r.prdata[7:0] & r.amask) == 8'h00)  // [R9]
      else $error("Analog pin read back as one.");
   a_rc_delay: assert property (go_start && is_rc |=> r.state == ST_DELAY [*4])  // [R13]
      else $error("RC start did not wait one instruction cycle.");
   a_right_just: assert property (s_complete ##0 r.fmt |=> r.res_hi[7:2] == 6'h00)  // [R19]
      else $error("Right justified result has upper bits set.");
   a_sleep_abort: assert property (r.state == ST_CONV && !wr_ctrl0 && SLEEP && !is_rc
      |=> r.state == ST_PDOWN && !r.powered)  // [R15]
      else $error("Sleep with oscillator clock did not abort.");
   a_reset_off: assert property (disable iff (1'b0) RST |=> r.state == ST_OFF && !r.pwr)  // [R16]
      else $error("Reset did not turn the converter off.");
endmodule

// ==== testbench/adcsq_an_model.sv ====
// Purpose: Behavioural analog core: hold capacitor plus comparator against the trial code.
// Assumes: The bench gives the level of the selected channel as a 10-bit code.
// Notes:   An unpowered core answers with a toggling level, never a steady helpful one.
`timescale 1ns/1ps
module adcsq_an_model (
   input  wire logic       MCLK,       // System clock
   input  wire logic [9:0] LEVEL,      // Level on the selected channel
   input  wire logic       AN_SAMPLE,  // Hold capacitor connected
   input  wire logic [9:0] AN_TRIAL,   // Trial code
   input  wire logic       AN_POWER,   // Core powered
   output logic            AN_COMP     // Held level at or above trial
);
   logic [9:0] held = 10'h000;
   logic       comp = 1'b0;

   // The capacitor keeps its charge while disconnected, so only sampling moves it.
   always_ff @(posedge MCLK)
   begin
      if (AN_SAMPLE)
      begin
         held <= LEVEL;
      end
      comp <= AN_POWER ? (held >= AN_TRIAL) : ~comp;
   end

   assign AN_COMP = comp;
endmodule

// ==== testbench/adcsq_seq_tb.sv ====
// Purpose: Self-checking bench of the conversion sequencer over APB.
// Assumes: APB answers in two access cycles; the RC oscillator runs freely.
// Notes:   Timing checks allow a few cycles of slack for bus and register latency.
`timescale 1ns/1ps
`include "adcsq_params.svh"
module adcsq_seq_tb;
   logic        MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SLEEP, RC_CLK;
   logic [7:0]  PADDR, PIN_IN;
   logic [31:0] PWDATA, PRDATA, rdat;
   logic        AN_COMP, AN_SAMPLE, AN_POWER, WAKE, DONE_FLAG, rerr;
   logic [2:0]  AN_CHANNEL;
   logic [9:0]  AN_TRIAL, level;
   logic [15:0] last_res;
   int          err_total = 0;
   int          n_checks = 0;

   adcsq_seq u_adcsq_seq (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .SLEEP(SLEEP), .RC_CLK(RC_CLK), .PIN_IN(PIN_IN), .AN_COMP(AN_COMP),
      .AN_CHANNEL(AN_CHANNEL), .AN_SAMPLE(AN_SAMPLE), .AN_TRIAL(AN_TRIAL),
      .AN_POWER(AN_POWER), .WAKE(WAKE), .DONE_FLAG(DONE_FLAG));
   adcsq_an_model u_adcsq_an_model (.MCLK(MCLK), .LEVEL(level), .AN_SAMPLE(AN_SAMPLE),
      .AN_TRIAL(AN_TRIAL), .AN_POWER(AN_POWER), .AN_COMP(AN_COMP));

   // Clocks: the RC oscillator is free running; its edges fall on MCLK falling edges.
   always #5 MCLK = ~MCLK;
   // A 1.6 us period keeps the RC bit period at the legal minimum.
   always #800 RC_CLK = ~RC_CLK;

   task automatic end_sim();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      check({31'h0, got}, {31'h0, exp});
   endtask

   // One APB transfer; the request is held until PREADY is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do
      begin
         @(posedge MCLK);
         n++;
      end
      while (PREADY !== 1'b1 && n < 20);
      if (PREADY !== 1'b1)
      begin
         err_total++;
         end_sim();
      end
      rdat = PRDATA;
      rerr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdat, exp);
   endtask

   // Bounded wait: 0 done flag, 1 sampling, 2 wake pulse, 3 core powered down.
   task automatic wait_hi(input int sel, input int lim, output int n);
      logic s;
      n = 0;
      s = 1'b0;
      while (s !== 1'b1)
      begin
         @(posedge MCLK);
         n++;
         s = sel == 0 ? DONE_FLAG : sel == 1 ? AN_SAMPLE : sel == 2 ? WAKE : ~AN_POWER;
         if (n > lim)
         begin
            err_total++;
            end_sim();
         end
      end
   endtask

   task automatic regs_port();
      rdc(`ADCSQ_OFF_CTRL0, 32'h0);
      rdc(`ADCSQ_OFF_CTRL1, 32'h0);
      rdc(`ADCSQ_OFF_STATUS, 32'h0);
      rdc(`ADCSQ_OFF_AMASK, 32'hff);
      rdc(`ADCSQ_OFF_PORT, 32'h0);
      apb(1'b1, `ADCSQ_OFF_AMASK, 32'h0f);
      rdc(`ADCSQ_OFF_PORT, 32'ha0);
      rdc(8'h1c, 32'h0);
      chk1(rerr, 1'b1);
   endtask

   // Full conversion at a divided clock; format and channel vary per call.
   task automatic conv(input logic [1:0] cs, input logic fmt, input logic [9:0] lv);
      int n;
      int t;
      t = cs == 2'h0 ? 2 : cs == 2'h1 ? 8 : 32;
      last_res = fmt ? {6'h00, lv} : {lv, 6'h00};
      level <= lv;
      apb(1'b1, `ADCSQ_OFF_CTRL1, {24'h0, fmt, 7'h00});
      apb(1'b1, `ADCSQ_OFF_CTRL0, {24'h0, cs, 1'b0, cs, 3'h1});
      repeat (40) @(posedge MCLK);
      apb(1'b1, `ADCSQ_OFF_CTRL0, {24'h0, cs, 1'b0, cs, 3'h5});
      check({29'h0, AN_CHANNEL}, {29'h0, 1'b0, cs});
      check({22'h0, AN_TRIAL}, 32'h0);
      wait_hi(0, 600, n);
      chk1(n >= 12 * t, 1'b1);
      chk1(n <= 12 * t + 4, 1'b1);
      chk1(AN_SAMPLE, 1'b0);
      wait_hi(1, 100, n);
      chk1(n >= 2 * t - 2 && n <= 2 * t + 3, 1'b1);
      apb(1'b1, `ADCSQ_OFF_RESH, 32'ha5);
      rdc(`ADCSQ_OFF_RESH, {24'h0, last_res[15:8]});
      rdc(`ADCSQ_OFF_RESL, {24'h0, last_res[7:0]});
      rdc(`ADCSQ_OFF_CTRL0, {24'h0, cs, 1'b0, cs, 3'h1});
      rdc(`ADCSQ_OFF_STATUS, 32'h1);
      apb(1'b1, `ADCSQ_OFF_STATUS, 32'h1);
      chk1(DONE_FLAG, 1'b0);
   endtask

   // Abort mid-conversion, then a sleep with a divided clock.
   task automatic abort_sleep();
      int n;
      level <= ~level;
      apb(1'b1, `ADCSQ_OFF_CTRL0, 32'h95);
      repeat (100) @(posedge MCLK);
      apb(1'b1, `ADCSQ_OFF_CTRL0, 32'h91);
      chk1(AN_SAMPLE, 1'b0);
      wait_hi(1, 100, n);
      chk1(n >= 62 && n <= 67, 1'b1);
      chk1(DONE_FLAG, 1'b0);
      rdc(`ADCSQ_OFF_RESH, {24'h0, last_res[15:8]});
      rdc(`ADCSQ_OFF_RESL, {24'h0, last_res[7:0]});
      apb(1'b1, `ADCSQ_OFF_CTRL0, 32'h45);
      repeat (20) @(posedge MCLK);
      SLEEP <= 1'b1;
      repeat (3) @(posedge MCLK);
      chk1(AN_POWER, 1'b0);
      SLEEP <= 1'b0;
      wait_hi(1, 100, n);
      rdc(`ADCSQ_OFF_CTRL0, 32'h41);
      chk1(DONE_FLAG, 1'b0);
   endtask

   // RC clock conversion during sleep, with and without the interrupt enable.
   task automatic rc_run(input logic ie);
      int n;
      level <= {ie, 9'h0e7};
      last_res = {ie, 9'h0e7, 6'h00};
      apb(1'b1, `ADCSQ_OFF_STATUS, {30'h0, ie, 1'b1});
      apb(1'b1, `ADCSQ_OFF_CTRL0, 32'hed);
      SLEEP <= 1'b1;
      wait_hi(ie ? 2 : 0, 2100, n);
      if (!ie)
      begin
         wait_hi(3, 400, n);
      end
      SLEEP <= 1'b0;
      rdc(`ADCSQ_OFF_CTRL0, 32'he9);
      rdc(`ADCSQ_OFF_RESH, {24'h0, last_res[15:8]});
      rdc(`ADCSQ_OFF_RESL, {24'h0, last_res[7:0]});
      wait_hi(1, 400, n);
   endtask

   // Reset in mid-conversion, then the result words as plain registers.
   task automatic reset_mid();
      apb(1'b1, `ADCSQ_OFF_CTRL0, 32'h45);
      repeat (20) @(posedge MCLK);
      RST <= 1'b1;
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      chk1(AN_POWER, 1'b0);
      rdc(`ADCSQ_OFF_CTRL0, 32'h0);
      rdc(`ADCSQ_OFF_RESH, {24'h0, last_res[15:8]});
      apb(1'b1, `ADCSQ_OFF_RESH, 32'h5a);
      apb(1'b1, `ADCSQ_OFF_RESL, 32'h3c);
      rdc(`ADCSQ_OFF_RESH, 32'h5a);
      rdc(`ADCSQ_OFF_RESL, 32'h3c);
   endtask

   // Main sequence; every scenario judges its own results.
   initial
   begin
      MCLK = 1'b0;
      RC_CLK = 1'b0;
      RST = 1'b1;
      {PSEL, PENABLE, PWRITE, SLEEP} = 4'h0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      PIN_IN = 8'ha5;
      level = 10'h000;
      repeat (10) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      regs_port();
      conv(2'h0, 1'b0, 10'h2d7);
      conv(2'h1, 1'b1, 10'h3ff);
      conv(2'h2, 1'b0, 10'h001);
      abort_sleep();
      rc_run(1'b1);
      rc_run(1'b0);
      reset_mid();
      end_sim();
   end

   // Cuts a hung run short.
   initial
   begin
      repeat (90000) @(posedge MCLK);
      err_total++;
      end_sim();
   end
endmodule
